// file: hdl/emim_fall_detect.sv
module emim_fall_detect (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic level_in,
  output logic fall_out
);

  logic prev_r;

  // Idle level is high, so a reset never fakes a falling edge.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= level_in;
    end
  end

  assign fall_out = prev_r & ~level_in;

endmodule // emim_fall_detect

// file: hdl/emim_irq_mask.sv
// Summary of operation
// - Per-phase reactive sign change interrupts, total or fundamental by select.
// - Bit 13 enables interrupt on second pulse datapath sum sign change.
// - Bit 18 enables interrupt on third pulse datapath sum sign change.
// - Bit 14 enables interrupt on first calibration pulse falling edge.
// - Bits 15, 16 enable interrupts on second, third pulse falling edges.
// - Pulse interrupts still work while the pulse pin is switched off.
// - Three-bit fields in pulse mode register pick each pulse power type.
// - Bit 17 enables interrupt when periodic computations complete.
// - First enable bits 31 to 19 reserved, zero, without effect.
// - Second bit 0 enables interrupt on no-load entry, total powers.
// - Second bit 1 enables fundamental no-load interrupt, ignored without fundamentals.
// - Second bit 2 enables interrupt on no-load entry, apparent power.
// - Second bits 3 to 5 enable missing voltage crossing interrupts.
// - Second bits 6 to 8 enable missing current crossing interrupts.
// - Second bits 9 to 11 enable voltage crossing detect interrupts.
// - Second bits 12, 13 enable phase A, B current crossing interrupts.
// - Without reactive measurement, reactive enables store but do nothing.
// - Second bit 14 enables phase C current crossing interrupt.
//
// Added by the designer: the APB interface to the registers.
module emim_irq_mask #(
  parameter bit HAS_REACTIVE = 1'b1,
  parameter bit HAS_FUND = 1'b1
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [emim_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire emim_pkg::emim_events_t events_in,
  input wire logic [2:0] cal_pulse_raw_in,
  output logic cal_pulse_out1_out,
  output logic cal_pulse_out2_out,
  output logic cal_pulse_out3_out,
  output logic [emim_pkg::SEL_W-1:0] pulse1_power_sel_out,
  output logic [emim_pkg::SEL_W-1:0] pulse2_power_sel_out,
  output logic [emim_pkg::SEL_W-1:0] pulse3_power_sel_out,
  output logic irq_n_out
);
  import emim_pkg::*;

  // ==========================================================
  // Registers
  // ==========================================================
  logic [31:0] en_first_r;
  logic [31:0] en_second_r;
  logic [31:0] st_first_r;
  logic [31:0] st_second_r;
  logic [31:0] acc_mode_r;
  logic [31:0] pulse_mode_r;
  logic [31:0] prdata_r;
  logic slverr_r;
  logic [2:0] pin_r;
  logic irq_n_r;

  // ==========================================================
  // APB decode
  // ==========================================================
  wire logic setup = psel_in & ~penable_in;
  wire logic access = psel_in & penable_in;
  wire logic sel_en1 = (paddr_in == ADDR_ENABLE_FIRST);
  wire logic sel_en2 = (paddr_in == ADDR_ENABLE_SECOND);
  wire logic sel_st1 = (paddr_in == ADDR_STATUS_FIRST);
  wire logic sel_st2 = (paddr_in == ADDR_STATUS_SECOND);
  wire logic sel_acc = (paddr_in == ADDR_ACC_MODE);
  wire logic sel_pm = (paddr_in == ADDR_PULSE_MODE);
  wire logic mapped = sel_en1 | sel_en2 | sel_st1 | sel_st2 | sel_acc | sel_pm;
  wire logic wr = access & pwrite_in & mapped;
  wire logic [31:0] rd_word =
    sel_en1 ? en_first_r :
    sel_en2 ? en_second_r :
    sel_st1 ? st_first_r :
    sel_st2 ? st_second_r :
    sel_acc ? acc_mode_r :
    sel_pm ? pulse_mode_r : RESET_WORD;

  // Read data and error are captured in the setup cycle, so the
  // access cycle always completes without wait states.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      prdata_r <= RESET_WORD;
      slverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite_in ? RESET_WORD : rd_word;
      slverr_r <= ~mapped;
    end
  end

  assign prdata_out = prdata_r;
  assign pready_out = 1'b1;
  assign pslverr_out = slverr_r & access;

  // ==========================================================
  // Control registers
  // ==========================================================
  // reserved bits
  // Only implemented bits are stored; the rest read back as zero.
  wire logic [31:0] en_first_nxt =
    (wr & sel_en1) ? (pwdata_in & FIRST_IMPL) : en_first_r;
  wire logic [31:0] en_second_nxt =
    (wr & sel_en2) ? (pwdata_in & SECOND_IMPL) : en_second_r;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      en_first_r <= RESET_WORD;
      en_second_r <= RESET_WORD;
      acc_mode_r <= RESET_WORD;
      pulse_mode_r <= RESET_WORD;
    end else begin
      en_first_r <= en_first_nxt;
      en_second_r <= en_second_nxt;
      if (wr && sel_acc) acc_mode_r <= pwdata_in & ACC_IMPL;
      if (wr && sel_pm) pulse_mode_r <= pwdata_in & PULSE_IMPL;
    end
  end

  assign pulse1_power_sel_out = pulse_mode_r[SEL1_LSB +: SEL_W];
  assign pulse2_power_sel_out = pulse_mode_r[SEL2_LSB +: SEL_W];
  assign pulse3_power_sel_out = pulse_mode_r[SEL3_LSB +: SEL_W];

  // ==========================================================
  // Calibration pulse edges
  // ==========================================================
  wire logic [2:0] pulse_fall;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_fall
      emim_fall_detect u_fall (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .level_in(cal_pulse_raw_in[gi]),
        .fall_out(pulse_fall[gi])
      );
    end
  endgenerate

  // pin suppressed
  // A switched-off pin idles high, but edges are taken from the
  // internal pulse train so the flags keep working.
  wire logic [2:0] pulse_off = pulse_mode_r[BIT_PULSE1_OFF +: 3];

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pin_r <= 3'h7;
    end else begin
      pin_r <= cal_pulse_raw_in | pulse_off;
    end
  end

  assign cal_pulse_out1_out = pin_r[0];
  assign cal_pulse_out2_out = pin_r[1];
  assign cal_pulse_out3_out = pin_r[2];

  // ==========================================================
  // Event collection
  // ==========================================================
  wire logic [31:0] ev_first;
  wire logic [31:0] ev_second;
  wire logic react_src = acc_mode_r[BIT_REACT_SRC];

  wire logic [2:0] react_flip = react_src ? events_in.react_fund_flip :
                                            events_in.react_total_flip;

  assign ev_first[BIT_REACT_A-1:0] = '0;
  assign ev_first[BIT_REACT_A +: 3] = react_flip;
  assign ev_first[BIT_SUM2] = events_in.sum2_flip;
  assign ev_first[BIT_PULSE1 +: 3] = pulse_fall;
  assign ev_first[BIT_DONE] = events_in.compute_done;
  assign ev_first[BIT_SUM3] = events_in.sum3_flip;
  assign ev_first[31:BIT_RSVD_LO] = '0;

  assign ev_second[BIT_NL_TOTAL] = events_in.noload_total;
  assign ev_second[BIT_NL_FUND] = events_in.noload_fund;
  assign ev_second[BIT_NL_APP] = events_in.noload_apparent;
  assign ev_second[BIT_VMISS_A +: 3] = events_in.volt_missing;
  assign ev_second[BIT_IMISS_A +: 3] = events_in.curr_missing;
  assign ev_second[BIT_VCROSS_A +: 3] = events_in.volt_cross;
  assign ev_second[BIT_ICROSS_A +: 3] = events_in.curr_cross;
  assign ev_second[31:BIT_ICROSS_A+3] = '0;

  // ==========================================================
  // Sticky status flags
  // ==========================================================
  wire logic [31:0] clr_first = (wr & sel_st1) ? pwdata_in : RESET_WORD;
  wire logic [31:0] clr_second = (wr & sel_st2) ? pwdata_in : RESET_WORD;

  // flags ignore enables
  // A write of one clears a flag, and a new event in the same cycle wins.
  wire logic [31:0] st_first_nxt =
    (st_first_r & ~clr_first) | (ev_first & FIRST_IMPL);
  wire logic [31:0] st_second_nxt =
    (st_second_r & ~clr_second) | (ev_second & SECOND_IMPL);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_first_r <= RESET_WORD;
      st_second_r <= RESET_WORD;
    end else begin
      st_first_r <= st_first_nxt;
      st_second_r <= st_second_nxt;
    end
  end

  // ==========================================================
  // Interrupt request
  // ==========================================================
  // variant gating
  wire logic [31:0] eff_mask_first =
    FIRST_IMPL & ~(HAS_REACTIVE ? RESET_WORD : REACT_EN_MASK);
  wire logic [31:0] eff_mask_second =
    SECOND_IMPL & ~(HAS_FUND ? RESET_WORD : FUND_EN_MASK);
  wire logic [31:0] eff_first = en_first_r & eff_mask_first;
  wire logic [31:0] eff_second = en_second_r & eff_mask_second;
  // The request uses next-cycle enables, so a mask write and a flag
  // clear both reach the pin in the same cycle as the registers.
  wire logic [31:0] eff_first_nxt = en_first_nxt & eff_mask_first;
  wire logic [31:0] eff_second_nxt = en_second_nxt & eff_mask_second;
  wire logic irq_pend_nxt = |(st_first_nxt & eff_first_nxt) |
                            |(st_second_nxt & eff_second_nxt);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_n_r <= 1'b1;
    end else begin
      irq_n_r <= ~irq_pend_nxt;
    end
  end

  assign irq_n_out = irq_n_r;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  react_fund_flag_a: assert property (
    (react_src && events_in.react_fund_flip[0] && eff_first_nxt[BIT_REACT_A])
    |=> (st_first_r[BIT_REACT_A] && !irq_n_out))
    else $error("fundamental reactive flip did not raise request");

  sum3_sign_a: assert property (
    events_in.sum3_flip |=> st_first_r[BIT_SUM3])
    else $error("third sum sign change not flagged");

  pulse1_irq_a: assert property (
    (eff_first_nxt[BIT_PULSE1] && $fell(cal_pulse_raw_in[0]))
    |=> !irq_n_out)
    else $error("first pulse edge did not raise request");

  pulse3_flag_a: assert property (
    $fell(cal_pulse_raw_in[2]) |=> st_first_r[BIT_PULSE1+2])
    else $error("third pulse edge not flagged");

  pin_off_flag_a: assert property (
    (pulse_off[1] && $fell(cal_pulse_raw_in[1]))
    |=> (st_first_r[BIT_PULSE1+1] && cal_pulse_out2_out))
    else $error("suppressed pin lost its flag or went low");

  pulse_sel_write_a: assert property (
    (wr && sel_pm) |=> (pulse2_power_sel_out ==
                        $past(pwdata_in[SEL2_LSB +: SEL_W])))
    else $error("pulse select field not taken from write");

  reserved_read_a: assert property (
    (setup && !pwrite_in && sel_en1) |=> (prdata_out[31:BIT_RSVD_LO] == '0))
    else $error("reserved enable bits read nonzero");

  missing_volt_a: assert property (
    events_in.volt_missing[1] |=> st_second_r[BIT_VMISS_A+1])
    else $error("missing voltage crossing not flagged");

  reactive_variant_a: assert property (
    (!HAS_REACTIVE && (en_first_r & ~REACT_EN_MASK) == '0 &&
     en_second_r == '0) |-> irq_n_out)
    else $error("reactive enable active on variant without it");

  curr_c_cross_a: assert property (
    (events_in.curr_cross[2] && eff_second_nxt[BIT_ICROSS_A+2])
    |=> !irq_n_out)
    else $error("phase C current crossing did not raise request");

  set_wins_a: assert property (
    (wr && sel_st2 && pwdata_in[BIT_VCROSS_A] && events_in.volt_cross[0])
    |=> st_second_r[BIT_VCROSS_A])
    else $error("clear beat a simultaneous event");

  masked_quiet_a: assert property (
    ((st_first_r & eff_first) == '0 && (st_second_r & eff_second) == '0)
    |-> irq_n_out)
    else $error("request low with nothing enabled pending");

  fund_variant_a: assert property (
    (!HAS_FUND && en_first_r == '0 && (en_second_r & ~FUND_EN_MASK) == '0)
    |-> irq_n_out)
    else $error("fundamental no-load enable active on variant");

  sum2_sign_a: assert property (
    events_in.sum2_flip |=> st_first_r[BIT_SUM2])
    else $error("second sum sign change not flagged");

  done_irq_a: assert property (
    (events_in.compute_done && eff_first_nxt[BIT_DONE]) |=> !irq_n_out)
    else $error("computation done did not raise request");

  noload_total_a: assert property (
    events_in.noload_total |=> st_second_r[BIT_NL_TOTAL])
    else $error("total no-load entry not flagged");

  noload_app_a: assert property (
    events_in.noload_apparent |=> st_second_r[BIT_NL_APP])
    else $error("apparent no-load entry not flagged");

  missing_curr_a: assert property (
    events_in.curr_missing[0] |=> st_second_r[BIT_IMISS_A])
    else $error("missing current crossing not flagged");

  volt_c_cross_a: assert property (
    (events_in.volt_cross[2] && eff_second_nxt[BIT_VCROSS_A+2])
    |=> !irq_n_out)
    else $error("phase C voltage crossing did not raise request");

  curr_b_cross_a: assert property (
    events_in.curr_cross[1] |=> st_second_r[BIT_ICROSS_A+1])
    else $error("phase B current crossing not flagged");

  pin_follow_a: assert property (
    cal_pulse_out1_out ==
      ($past(cal_pulse_raw_in[0]) | $past(pulse_off[0])))
    else $error("first pulse pin does not follow train and off bit");

  irq_cause_a: assert property (
    !irq_n_out |-> ((st_first_r & eff_first) != '0 ||
                    (st_second_r & eff_second) != '0))
    else $error("request low without an enabled pending flag");

endmodule // emim_irq_mask

// file: hdl/emim_pkg.sv
package emim_pkg;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam int ADDR_W = 18;
  localparam logic [15:0] IDX_ENABLE_FIRST = 16'hE50A;
  localparam logic [15:0] IDX_ENABLE_SECOND = 16'hE50B;
  localparam logic [15:0] IDX_STATUS_FIRST = 16'hE50C;
  localparam logic [15:0] IDX_STATUS_SECOND = 16'hE50D;
  localparam logic [15:0] IDX_ACC_MODE = 16'hE50E;
  localparam logic [15:0] IDX_PULSE_MODE = 16'hE50F;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE_FIRST = {IDX_ENABLE_FIRST, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_ENABLE_SECOND =
    {IDX_ENABLE_SECOND, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS_FIRST = {IDX_STATUS_FIRST, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS_SECOND =
    {IDX_STATUS_SECOND, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_ACC_MODE = {IDX_ACC_MODE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_PULSE_MODE = {IDX_PULSE_MODE, 2'b00};

  // ==========================================================
  // Reset values and implemented bits
  // ==========================================================
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [31:0] FIRST_IMPL = 32'h0007_FC00;
  localparam logic [31:0] SECOND_IMPL = 32'h0000_7FFF;
  localparam logic [31:0] ACC_IMPL = 32'h0000_0080;
  localparam logic [31:0] PULSE_IMPL = 32'h0000_0FFF;
  localparam logic [31:0] REACT_EN_MASK = 32'h0000_1C00;
  localparam logic [31:0] FUND_EN_MASK = 32'h0000_0002;

  // ==========================================================
  // Field positions, first enable and status word
  // ==========================================================
  localparam int BIT_REACT_A = 10;
  localparam int BIT_SUM2 = 13;
  localparam int BIT_PULSE1 = 14;
  localparam int BIT_DONE = 17;
  localparam int BIT_SUM3 = 18;
  localparam int BIT_RSVD_LO = 19;

  // ==========================================================
  // Field positions, second enable and status word
  // ==========================================================
  localparam int BIT_NL_TOTAL = 0;
  localparam int BIT_NL_FUND = 1;
  localparam int BIT_NL_APP = 2;
  localparam int BIT_VMISS_A = 3;
  localparam int BIT_IMISS_A = 6;
  localparam int BIT_VCROSS_A = 9;
  localparam int BIT_ICROSS_A = 12;

  // ==========================================================
  // Mode register fields
  // ==========================================================
  localparam int BIT_REACT_SRC = 7;
  localparam int BIT_PULSE1_OFF = 9;
  localparam int SEL_W = 3;
  localparam int SEL1_LSB = 0;
  localparam int SEL2_LSB = 3;
  localparam int SEL3_LSB = 6;

  // ==========================================================
  // Event carrier from the measurement datapath
  // ==========================================================
  typedef struct packed {
    logic [2:0] react_total_flip;
    logic [2:0] react_fund_flip;
    logic sum2_flip;
    logic sum3_flip;
    logic compute_done;
    logic noload_total;
    logic noload_fund;
    logic noload_apparent;
    logic [2:0] volt_missing;
    logic [2:0] curr_missing;
    logic [2:0] volt_cross;
    logic [2:0] curr_cross;
  } emim_events_t;

endpackage

// file: verif/emim_host.sv
module emim_host (
  input wire logic clk_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [emim_pkg::ADDR_W-1:0] paddr_out,
  output logic [31:0] pwdata_out,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import emim_pkg::*;

  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = '0;
    pwdata_out = 32'h0;
  end

  // ==========================================================
  // One APB transfer, held until pready is seen high.
  // ==========================================================
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err);
    @(posedge clk_in);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= wr;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'b1;
    @(posedge clk_in);
    while (pready_in !== 1'b1) @(posedge clk_in);
    q = prdata_in;
    err = pslverr_in;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic err;
    xfer(1'b1, a, d, q, err);
  endtask

  task automatic service(input logic [ADDR_W-1:0] a, input logic [31:0] m);
    wr(a, m);
  endtask
endmodule // emim_host

// file: verif/emim_irq_mask_tb.sv
module emim_irq_mask_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import emim_pkg::*;

  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, irq_n, pin1, pin2, pin3;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  emim_events_t events = '0;
  logic [2:0] raw = 3'h7;
  logic [SEL_W-1:0] sel1, sel2, sel3;
  logic irq_n_var;
  int fail_count = 0;
  int check_count = 0;

  always #12.5 clk_in = ~clk_in;

  emim_irq_mask i_dut (.clk_in(clk_in), .reset_in(reset_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .events_in(events),
    .cal_pulse_raw_in(raw), .cal_pulse_out1_out(pin1),
    .cal_pulse_out2_out(pin2), .cal_pulse_out3_out(pin3),
    .pulse1_power_sel_out(sel1), .pulse2_power_sel_out(sel2),
    .pulse3_power_sel_out(sel3), .irq_n_out(irq_n));

  emim_host i_host (.clk_in(clk_in), .psel_out(psel),
    .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
    .pwdata_out(pwdata), .prdata_in(prdata), .pready_in(pready),
    .pslverr_in(pslverr));

  emim_irq_mask #(.HAS_REACTIVE(1'b0), .HAS_FUND(1'b0)) i_dut_var (
    .clk_in(clk_in), .reset_in(reset_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(), .pready_out(), .pslverr_out(),
    .events_in(events), .cal_pulse_raw_in(raw), .cal_pulse_out1_out(),
    .cal_pulse_out2_out(), .cal_pulse_out3_out(),
    .pulse1_power_sel_out(), .pulse2_power_sel_out(),
    .pulse3_power_sel_out(), .irq_n_out(irq_n_var));

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] q,
                    output logic err);
    i_host.xfer(1'b0, a, 32'h0, q, err);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    logic [31:0] q;
    logic err;
    rd(a, q, err);
    chk(q, e, "read data");
    chk(32'(err), 32'h0, "unexpected slave error");
  endtask

  function automatic emim_events_t mk(input bit sec, input int b);
    emim_events_t e;
    logic [18:0] v;
    e = '0;
    v = 19'(1) << b;
    if (sec) begin
      e.noload_total = v[0];
      e.noload_fund = v[1];
      e.noload_apparent = v[2];
      e.volt_missing = v[5:3];
      e.curr_missing = v[8:6];
      e.volt_cross = v[11:9];
      e.curr_cross = v[14:12];
    end else begin
      e.react_total_flip = v[12:10];
      e.sum2_flip = v[13];
      e.compute_done = v[17];
      e.sum3_flip = v[18];
    end
    return e;
  endfunction

  task automatic fire_ev(input emim_events_t e);
    @(posedge clk_in);
    events <= e;
    @(posedge clk_in);
    events <= '0;
    #1;
  endtask

  task automatic fire_raw(input int i);
    @(posedge clk_in);
    raw[i] <= 1'b0;
    @(posedge clk_in);
    raw[i] <= 1'b1;
    #1;
  endtask

  task automatic fire(input bit sec, input int b);
    if (!sec && b >= 14 && b <= 16) fire_raw(b - 14);
    else fire_ev(mk(sec, b));
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_reset();
    rd_chk(ADDR_ENABLE_FIRST, 32'h0);
    rd_chk(ADDR_ENABLE_SECOND, 32'h0);
    rd_chk(ADDR_PULSE_MODE, 32'h0);
    chk({29'h0, pin3, pin2, pin1}, 32'h7, "pins idle");
    chk(32'(irq_n), 32'h1, "irq idle");
    chk(32'(pready), 32'h1, "ready not high");
  endtask

  task automatic t_regs();
    logic [31:0] q;
    logic err;
    i_host.wr(ADDR_ENABLE_FIRST, 32'hFFFF_FFFF);
    rd_chk(ADDR_ENABLE_FIRST, FIRST_IMPL);
    i_host.wr(ADDR_ENABLE_SECOND, 32'hFFFF_FFFF);
    rd_chk(ADDR_ENABLE_SECOND, SECOND_IMPL);
    i_host.wr(ADDR_ENABLE_FIRST, 32'hFFF8_0000);
    i_host.wr(ADDR_ENABLE_SECOND, 32'h0);
    fire_ev(mk(1'b0, 17));
    chk(32'(irq_n), 32'h1, "reserved bits raised irq");
    i_host.service(ADDR_STATUS_FIRST, 32'h0002_0000);
    i_host.wr(ADDR_ENABLE_FIRST, 32'h0);
    rd(18'h0, q, err);
    chk(q, 32'h0, "unmapped read data");
    chk(32'(err), 32'h1, "unmapped no error");
  endtask

  task automatic t_pulse();
    i_host.wr(ADDR_PULSE_MODE, 32'h0000_0F95);
    #1;
    chk({23'h0, sel3, sel2, sel1}, 32'h0000_0195, "power select");
    for (int i = 0; i < 3; i++) begin
      fire_raw(i);
      chk({29'h0, pin3, pin2, pin1}, 32'h7, "pin not off");
    end
    i_host.wr(ADDR_PULSE_MODE, 32'h0000_0195);
    fire_raw(0);
    chk(32'(pin1), 32'h0, "pin did not fall");
    i_host.service(ADDR_STATUS_FIRST, 32'h0001_C000);
    i_host.wr(ADDR_PULSE_MODE, 32'h0000_0E00);
  endtask

  task automatic ev_case(input bit sec, input int b);
    logic [ADDR_W-1:0] en_a, st_a;
    logic [31:0] m;
    en_a = sec ? ADDR_ENABLE_SECOND : ADDR_ENABLE_FIRST;
    st_a = sec ? ADDR_STATUS_SECOND : ADDR_STATUS_FIRST;
    m = 32'h1 << b;
    i_host.wr(en_a, m);
    fire(sec, b);
    chk(32'(irq_n), 32'h0, "irq not raised");
    rd_chk(st_a, m);
    i_host.service(st_a, m);
    #1;
    chk(32'(irq_n), 32'h1, "irq not released");
    i_host.wr(en_a, 32'h0);
    fire(sec, b);
    chk(32'(irq_n), 32'h1, "masked irq raised");
    rd_chk(st_a, m);
    i_host.service(st_a, m);
  endtask

  task automatic t_react_sel();
    emim_events_t e;
    e = '0;
    e.react_fund_flip = 3'h1;
    i_host.wr(ADDR_ACC_MODE, 32'h0000_0080);
    i_host.wr(ADDR_ENABLE_FIRST, 32'h0000_0400);
    fire_ev(e);
    chk(32'(irq_n), 32'h0, "fundamental flip ignored");
    i_host.service(ADDR_STATUS_FIRST, 32'h0000_0400);
    e = '0;
    e.react_total_flip = 3'h1;
    fire_ev(e);
    chk(32'(irq_n), 32'h1, "total flip not deselected");
    i_host.wr(ADDR_ACC_MODE, 32'h0);
    i_host.service(ADDR_STATUS_FIRST, 32'h0000_0400);
  endtask

  task automatic t_variant();
    emim_events_t e;
    e = '0;
    e.react_total_flip = 3'h7;
    i_host.wr(ADDR_ENABLE_FIRST, REACT_EN_MASK);
    fire_ev(e);
    chk(32'(irq_n), 32'h0, "reactive flip ignored");
    chk(32'(irq_n_var), 32'h1, "reactive enable acted on variant");
    i_host.service(ADDR_STATUS_FIRST, REACT_EN_MASK);
    i_host.wr(ADDR_ENABLE_FIRST, 32'h0);
    e = '0;
    e.noload_fund = 1'b1;
    i_host.wr(ADDR_ENABLE_SECOND, FUND_EN_MASK);
    fire_ev(e);
    chk(32'(irq_n), 32'h0, "fundamental no-load ignored");
    chk(32'(irq_n_var), 32'h1, "fundamental enable acted");
    i_host.service(ADDR_STATUS_SECOND, FUND_EN_MASK);
    i_host.wr(ADDR_ENABLE_SECOND, 32'h0);
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    t_reset();
    t_regs();
    t_pulse();
    for (int b = 10; b <= 18; b++) ev_case(1'b0, b);
    for (int b = 0; b <= 14; b++) ev_case(1'b1, b);
    t_react_sel();
    t_variant();
    give_verdict();
  end
endmodule // emim_irq_mask_tb
